// ==== core/sss_params.svh ====
// Constants of the synchronous serial shift unit: offsets, fields, resets, timing.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
// Register byte offsets
`define SSS_OFS_MODE        8'h00
`define SSS_OFS_RATE        8'h04
`define SSS_OFS_CTRL        8'h08
`define SSS_OFS_TXHOLD      8'h0C
`define SSS_OFS_STATUS      8'h10
`define SSS_OFS_RXHOLD      8'h14
// Mode register field
`define SSS_MODE_SYNC       7
// Control register fields
`define SSS_CTRL_TX_EMPTY_IE 7
`define SSS_CTRL_RX_FULL_IE 6
`define SSS_CTRL_TX_ENABLE  5
`define SSS_CTRL_RX_ON      4
`define SSS_CTRL_MP_WAIT    3
`define SSS_CTRL_TX_DONE_IE 2
`define SSS_CTRL_CLK_HI     1
`define SSS_CTRL_CLK_LO     0
// Status register fields
`define SSS_ST_TX_EMPTY     7
`define SSS_ST_RX_FULL      6
`define SSS_ST_OVERRUN      5
`define SSS_ST_FRAMING      4
`define SSS_ST_PARITY       3
`define SSS_ST_TX_DONE      2
// Reset values
`define SSS_MODE_RST        8'h00
`define SSS_RATE_RST        8'hFF
`define SSS_CTRL_RST        8'h00
`define SSS_TXHOLD_RST      8'hFF
`define SSS_RXHOLD_RST      8'h00
// Timing and framing
`define SSS_PRESCALE_SHIFT  2
`define SSS_LAST_BIT        3'h7
// Bus answers
`define SSS_RESP_OKAY       2'h0
`define SSS_RESP_SLVERR     2'h2
`endif

// ==== core/sss_pkg.sv ====
// Types shared by the synchronous serial shift unit.
// Assumes nothing beyond a SystemVerilog compiler.
package sss_pkg;
	// Transmitter sequencing
	typedef enum logic {SSS_TX_IDLE, SSS_TX_SHIFT} sss_tx_state_t;
	// One character
	typedef logic [7:0] sss_byte_t;
endpackage

// ==== core/sss_rate_gen.sv ====
// Internal serial clock generator: toggles the clock each half period while run.
// Assumes the engine raises run only while a transfer needs the clock.
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_rate_gen
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	sss_tick_if.gen   t
);
	logic [11:0] cnt;
	logic [11:0] half_len;
	logic        tick;

	// Half period in reference cycles
	assign half_len = ({4'h0, t.divisor} + 12'h001) << `SSS_PRESCALE_SHIFT;
	// A low clock always finishes its half so the pin parks high
	assign tick = (t.run || !t.sck_level) && (cnt == half_len - 12'h001);
	assign t.fall = tick && t.sck_level;
	assign t.rise = tick && !t.sck_level;

	// Half-period counter and clock level
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt         <= 12'h000;
			t.sck_level <= 1'h1;
		end
		else if (!t.run && t.sck_level)
			cnt <= 12'h000;
		else if (tick)
		begin
			cnt         <= 12'h000;
			t.sck_level <= !t.sck_level;
		end
		else
			cnt <= cnt + 12'h001;
	end
endmodule

// ==== core/sss_sync3.sv ====
// Three-stage input synchroniser; output follows once stages two and three agree.
// Assumes an asynchronous input and a reset already synchronous to ref_clk.
`timescale 1ns/1ps
module sss_sync3
#(
	parameter logic RST_VAL = 1'h1
)
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic s1;
	logic s2;
	logic s3;

	// Shift chain; only the second stage reads the first
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q  <= RST_VAL;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule

// ==== core/sss_tick_if.sv ====
// Link between the serial clock generator and the shift engine.
// Assumes both ends run on the reference clock.
`timescale 1ns/1ps
interface sss_tick_if;
	logic            run;
	sss_pkg::sss_byte_t divisor;
	logic            sck_level;
	logic            fall;
	logic            rise;
	// Generator side
	modport gen
	(
		input  run,
		input  divisor,
		output sck_level,
		output fall,
		output rise
	);
	// Engine side
	modport user
	(
		output run,
		output divisor,
		input  sck_level,
		input  fall,
		input  rise
	);
endinterface

// ==== core/sss_top.sv ====
// Clock synchronous serial shift unit with AXI4-Lite registers and DMA strobes.
// Assumes serial pins arrive asynchronous and the bus runs on ref_clk.
`timescale 1ns/1ps
`include "sss_params.svh"
//Contract
// - Transmitter and receiver independent, both double buffered
// - Transmit bit changes on falling clock edge
// - LSB first; line keeps last bit after
// - Exactly eight data bits, nothing appended
// - Clock source from mode and select bits
// - Internal clock: eight pulses, idle high
// - Internal receive clock runs until receive off; code also stops it on a receive error
// - Transmit disable sets empty, resets shifter
// - Receive disable keeps flags and held character
// - Empty clear loads shifter, sets empty, interrupts
// - External clock paces transmitter shifting
// - Bit seven checks empty: chain or finish
// - Clock pin high after transmission ends
// - Receive LSB first; store when buffer free
// - Receive error stops transfers, blocks full flag
// - Full interrupt, or error interrupt on overrun
// - Leftover parity/framing errors block everything
// - DMA access clears empty or full flag
// - Overrun sets flag, discards new character
// - No transmit start while error flag set
module sss_top
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	output logic             txd_o,
	output logic             txd_oe,
	input  wire logic        rxd_i,
	input  wire logic        dma_tx_wr,
	input  wire logic [7:0]  dma_tx_data,
	input  wire logic        dma_rx_rd,
	output logic [7:0]       dma_rx_data,
	output logic             tx_empty_irq,
	output logic             rx_full_irq,
	output logic             rx_error_irq,
	output logic             tx_done_irq
);
	// ****************************************************
	// Reset release and input synchronisers
	// ****************************************************
	logic [1:0]              rst_pipe;
	logic                    rst_n;
	logic                    sck_s;
	logic                    sck_s_d;
	logic                    rxd_s;
	sss_tick_if              tk ();

	// Release reset through two flops
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'h1};
	end
	assign rst_n = rst_pipe[1];

	sss_sync3 #(.RST_VAL(1'h1)) u_sck (.ref_clk(ref_clk), .rst_n(rst_n), .d(sck_i), .q(sck_s));
	sss_sync3 #(.RST_VAL(1'h1)) u_rxd (.ref_clk(ref_clk), .rst_n(rst_n), .d(rxd_i), .q(rxd_s));
	sss_rate_gen u_rate (.ref_clk(ref_clk), .rst_n(rst_n), .t(tk));

	// ****************************************************
	// Register bus slave
	// ****************************************************
	logic                    aw_held;
	logic                    w_held;
	logic [7:0]              aw_addr_q;
	logic [7:0]              w_data_q;
	logic                    w_lane0_q;
	logic                    wr_go;
	logic                    wr_known;
	logic                    wr_mode;
	logic                    wr_rate;
	logic                    wr_ctrl;
	logic                    wr_txh;
	logic                    wr_stat;
	logic [7:0]              rd_val;
	logic                    rd_known;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_held && w_held && !s_axi_bvalid;
	assign wr_known      = (aw_addr_q == `SSS_OFS_MODE) || (aw_addr_q == `SSS_OFS_RATE)
	                    || (aw_addr_q == `SSS_OFS_CTRL) || (aw_addr_q == `SSS_OFS_TXHOLD)
	                    || (aw_addr_q == `SSS_OFS_STATUS) || (aw_addr_q == `SSS_OFS_RXHOLD);
	assign wr_mode = wr_go && w_lane0_q && (aw_addr_q == `SSS_OFS_MODE);
	assign wr_rate = wr_go && w_lane0_q && (aw_addr_q == `SSS_OFS_RATE);
	assign wr_ctrl = wr_go && w_lane0_q && (aw_addr_q == `SSS_OFS_CTRL);
	assign wr_txh  = wr_go && w_lane0_q && (aw_addr_q == `SSS_OFS_TXHOLD);
	assign wr_stat = wr_go && w_lane0_q && (aw_addr_q == `SSS_OFS_STATUS);

	// Address and data captured in either order, answered once both are held
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held      <= 1'h0;
			w_held       <= 1'h0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 8'h00;
			w_lane0_q    <= 1'h0;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= `SSS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held   <= 1'h1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held    <= 1'h1;
				w_data_q  <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_held      <= 1'h0;
				w_held       <= 1'h0;
				s_axi_bvalid <= 1'h1;
				s_axi_bresp  <= wr_known ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'h0;
		end
	end

	// ****************************************************
	// Software registers and derived controls
	// ****************************************************
	sss_pkg::sss_byte_t      mode_reg;
	sss_pkg::sss_byte_t      bit_rate_reg;
	sss_pkg::sss_byte_t      ctrl_reg;
	sss_pkg::sss_byte_t      tx_hold_reg;
	sss_pkg::sss_byte_t      rx_hold_reg;
	logic                    tx_empty;
	logic                    rx_full;
	logic                    overrun;
	logic                    framing_err;
	logic                    parity_err;
	logic                    tx_done;
	logic                    sync_mode;
	logic                    tx_en;
	logic                    rx_en;
	logic                    int_clk;
	logic                    ext_clk;
	logic                    rx_err;

	// Mode, rate and control written by software only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_reg     <= `SSS_MODE_RST;
			bit_rate_reg <= `SSS_RATE_RST;
			ctrl_reg     <= `SSS_CTRL_RST;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= w_data_q;
			if (wr_rate)
				bit_rate_reg <= w_data_q;
			if (wr_ctrl)
				ctrl_reg <= w_data_q;
		end
	end

	assign sync_mode = mode_reg[`SSS_MODE_SYNC];
	assign tx_en     = ctrl_reg[`SSS_CTRL_TX_ENABLE];
	assign rx_en     = ctrl_reg[`SSS_CTRL_RX_ON];
	assign int_clk   = sync_mode && !ctrl_reg[`SSS_CTRL_CLK_HI];
	assign ext_clk   = sync_mode && ctrl_reg[`SSS_CTRL_CLK_HI];
	assign rx_err    = overrun || framing_err || parity_err;

	// Read mux, reserved bits zero
	always_comb
	begin
		rd_val   = 8'h00;
		rd_known = 1'h1;
		unique case ({s_axi_araddr[7:2], 2'h0})
			`SSS_OFS_MODE:   rd_val = mode_reg;
			`SSS_OFS_RATE:   rd_val = bit_rate_reg;
			`SSS_OFS_CTRL:   rd_val = ctrl_reg;
			`SSS_OFS_TXHOLD: rd_val = tx_hold_reg;
			`SSS_OFS_STATUS: rd_val = {tx_empty, rx_full, overrun, framing_err, parity_err,
			                           tx_done, 2'h0};
			`SSS_OFS_RXHOLD: rd_val = rx_hold_reg;
			default:         rd_known = 1'h0;
		endcase
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'h0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SSS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'h1;
			s_axi_rdata  <= {24'h00_0000, rd_val};
			s_axi_rresp  <= rd_known ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'h0;
	end

	// ****************************************************
	// Serial clock edges
	// ****************************************************
	logic                    fall;
	logic                    rise;
	sss_pkg::sss_tx_state_t  tx_state;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			sck_s_d <= 1'h1;
		else
			sck_s_d <= sck_s;
	end

	// Internal clock runs for a transmit frame or while receiving
	assign tk.run     = int_clk && !rx_err && (tx_state == sss_pkg::SSS_TX_SHIFT || rx_en);
	assign tk.divisor = bit_rate_reg;
	assign sck_o      = tk.sck_level;
	assign sck_oe     = int_clk;
	// Shared edges; an error freezes both directions
	assign fall = !rx_err && (int_clk ? tk.fall : (ext_clk && sck_s_d && !sck_s));
	assign rise = !rx_err && (int_clk ? tk.rise : (ext_clk && !sck_s_d && sck_s));

	// ****************************************************
	// Transmitter
	// ****************************************************
	sss_pkg::sss_byte_t      tx_shift_reg;
	logic [2:0]              tx_cnt;
	logic                    txd_q;
	logic                    tx_go;
	logic                    tx_last_rise;

	assign tx_last_rise = tx_state == sss_pkg::SSS_TX_SHIFT && rise && tx_cnt == `SSS_LAST_BIT;
	// Load from holding register when idle or at bit seven
	assign tx_go = tx_en && sync_mode && !rx_err && !tx_empty
	            && (tx_state == sss_pkg::SSS_TX_IDLE || tx_last_rise);

	// Shifter: bit out on falling edge, counted on rising edge
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state     <= sss_pkg::SSS_TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_cnt       <= 3'h0;
			txd_q        <= 1'h1;
		end
		else if (!tx_en)
		begin
			tx_state     <= sss_pkg::SSS_TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_cnt       <= 3'h0;
		end
		else if (tx_go)
		begin
			tx_state     <= sss_pkg::SSS_TX_SHIFT;
			tx_shift_reg <= tx_hold_reg;
			tx_cnt       <= 3'h0;
		end
		else if (tx_last_rise)
			tx_state <= sss_pkg::SSS_TX_IDLE;
		else if (tx_state == sss_pkg::SSS_TX_SHIFT && rise)
			tx_cnt <= tx_cnt + 3'h1;
		else if (tx_state == sss_pkg::SSS_TX_SHIFT && fall)
		begin
			txd_q        <= tx_shift_reg[0];
			tx_shift_reg <= {1'h0, tx_shift_reg[7:1]};
		end
	end

	assign txd_o  = txd_q;
	assign txd_oe = tx_en && sync_mode;

	// Holding register, from software or DMA
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_hold_reg <= `SSS_TXHOLD_RST;
		else if (dma_tx_wr)
			tx_hold_reg <= dma_tx_data;
		else if (wr_txh)
			tx_hold_reg <= w_data_q;
	end

	// Empty flag: hardware set wins over any clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_empty <= 1'h1;
		else if (!tx_en || tx_go)
			tx_empty <= 1'h1;
		else if (dma_tx_wr)
			tx_empty <= 1'h0;
		else if (wr_stat && !w_data_q[`SSS_ST_TX_EMPTY])
			tx_empty <= 1'h0;
	end

	// Done flag set when a frame ends with the buffer empty, cleared by the next load
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_done <= 1'h1;
		else if (tx_last_rise && tx_empty)
			tx_done <= 1'h1;
		else if (tx_go)
			tx_done <= 1'h0;
	end

	// ****************************************************
	// Receiver
	// ****************************************************
	sss_pkg::sss_byte_t      rx_shift_reg;
	sss_pkg::sss_byte_t      rx_next;
	logic [2:0]              rx_cnt;
	logic                    rx_done;

	assign rx_next = {rxd_s, rx_shift_reg[7:1]};
	assign rx_done = rx_en && sync_mode && rise && rx_cnt == `SSS_LAST_BIT;

	// Sample on rising edge, LSB first
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_shift_reg <= 8'h00;
			rx_cnt       <= 3'h0;
		end
		else if (!rx_en || !sync_mode)
			rx_cnt <= 3'h0;
		else if (rise)
		begin
			rx_shift_reg <= rx_next;
			rx_cnt       <= rx_cnt + 3'h1;
		end
	end

	// Holding register kept on overrun and on receive disable
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_hold_reg <= `SSS_RXHOLD_RST;
		else if (rx_done && !rx_full)
			rx_hold_reg <= rx_next;
	end
	assign dma_rx_data = rx_hold_reg;

	// Full flag: hardware set wins over clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_full <= 1'h0;
		else if (rx_done && !rx_full)
			rx_full <= 1'h1;
		else if (dma_rx_rd)
			rx_full <= 1'h0;
		else if (wr_stat && !w_data_q[`SSS_ST_RX_FULL])
			rx_full <= 1'h0;
	end

	// Error flags: software writes zero to clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			overrun     <= 1'h0;
			framing_err <= 1'h0;
			parity_err  <= 1'h0;
		end
		else
		begin
			if (rx_done && rx_full)
				overrun <= 1'h1;
			else if (wr_stat && !w_data_q[`SSS_ST_OVERRUN])
				overrun <= 1'h0;
			if (wr_stat && !w_data_q[`SSS_ST_FRAMING])
				framing_err <= 1'h0;
			if (wr_stat && !w_data_q[`SSS_ST_PARITY])
				parity_err <= 1'h0;
		end
	end

	// Interrupt request levels
	assign tx_empty_irq = tx_empty && ctrl_reg[`SSS_CTRL_TX_EMPTY_IE];
	assign rx_full_irq  = rx_full && !overrun && ctrl_reg[`SSS_CTRL_RX_FULL_IE];
	assign rx_error_irq = rx_err && ctrl_reg[`SSS_CTRL_RX_FULL_IE];
	assign tx_done_irq  = tx_done && ctrl_reg[`SSS_CTRL_TX_DONE_IE];

	// ****************************************************
	// Assertions
	// ****************************************************
	logic                    tx_fall_seen;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_fall_seen <= 1'h0;
		else
			tx_fall_seen <= fall && tx_state == sss_pkg::SSS_TX_SHIFT && tx_en && !tx_go;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_tx_load_sets: assert property (tx_go |=> tx_empty && tx_state == sss_pkg::SSS_TX_SHIFT
		&& tx_shift_reg == $past(tx_hold_reg) && tx_cnt == 3'h0) else $error("load failed");
	a_tx_off_clear: assert property (!tx_en |=> tx_empty && tx_state == sss_pkg::SSS_TX_IDLE
		&& tx_shift_reg == 8'h00) else $error("disable did not reset");
	a_txd_on_fall: assert property ($changed(txd_q) |-> tx_fall_seen)
		else $error("line moved off a falling edge");
	a_tx_end_hold: assert property (tx_last_rise && tx_empty |=> tx_done
		&& tx_state == sss_pkg::SSS_TX_IDLE && $stable(txd_q)) else $error("end wrong");
	a_rx_store_char: assert property (rx_done && !rx_full |=> rx_full
		&& rx_hold_reg == $past(rx_next)) else $error("character not stored");
	a_overrun_keep: assert property (rx_done && rx_full |=> overrun && $stable(rx_hold_reg))
		else $error("overrun mishandled");
	a_rx_off_keeps: assert property ($fell(rx_en) && !wr_stat && !dma_rx_rd |=> $stable(rx_full)
		&& $stable(overrun) && $stable(rx_hold_reg)) else $error("receive off lost");
	a_err_no_start: assert property (rx_err && tx_state == sss_pkg::SSS_TX_IDLE
		|=> tx_state == sss_pkg::SSS_TX_IDLE) else $error("start under error");
	a_err_no_full: assert property (rx_err && !rx_full |=> !rx_full)
		else $error("full set under error");
	a_sck_idle_high: assert property (!tk.run && sck_o |=> sck_o [*2])
		else $error("clock left high level");
	a_err_irq_swap: assert property ($rose(overrun) && ctrl_reg[`SSS_CTRL_RX_FULL_IE]
		|-> rx_error_irq && !rx_full_irq) else $error("wrong irq");
	a_dma_clear: assert property (dma_tx_wr && tx_en && !tx_go |=> !tx_empty)
		else $error("dma write kept empty");

	c_back_to_back: cover property (tx_last_rise && tx_go);
	c_tx_finish: cover property (tx_last_rise && tx_empty);
	c_rx_store: cover property (rx_done && !rx_full);
	c_rx_overrun: cover property (rx_done && rx_full);
endmodule

// ==== test/sss_link_partner.sv ====
// Far-side device of the synchronous serial link, behavioural.
// Assumes it sees the resolved clock and transmit line levels.
`timescale 1ns/1ps
module sss_link_partner
(
	input  wire logic       sck,
	input  wire logic       txd,
	input  wire logic [7:0] send_byte,
	output logic            rxd,
	output logic [7:0]      got_byte,
	output int              n_rise
);
	logic [2:0] idx = 3'h0;
	// Start values
	initial
	begin
		rxd = 1'b1;
		got_byte = 8'h00;
		n_rise = 0;
	end
	// Next bit, LSB first, on each falling clock edge
	always @(negedge sck)
	begin
		rxd <= send_byte[idx];
		idx <= idx + 3'h1;
	end
	// Capture the transmit line at each rising edge
	always @(posedge sck)
	begin
		got_byte <= {txd, got_byte[7:1]};
		n_rise <= n_rise + 1;
	end
endmodule

// ==== test/test_sss_top.sv ====
// Self-checking bench of the synchronous serial shift unit.
// Assumes the partner model and rate 1, a half period of 8 cycles.
`timescale 1ns/1ps
module test_sss_top;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [1:0] r;} sss_row_t;
	sss_row_t    rows [6] = '{'{8'h00, 8'h00, 2'h0}, '{8'h04, 8'hFF, 2'h0},
		'{8'h08, 8'h00, 2'h0}, '{8'h10, 8'h84, 2'h0}, '{8'h14, 8'h00, 2'h0},
		'{8'h18, 8'h00, 2'h2}};
	logic [7:0]  aw_addr, ar_addr, dtx_data, send_byte;
	logic [31:0] w_data;
	logic        ref_clk, rstn, aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic        sck_ext, dma_tx_wr, dma_rx_rd;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, sck_o, sck_oe, txd_o, txd_oe;
	logic        rxd, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] r_data;
	logic [7:0]  dma_rx_data, got_byte;
	int          n_rise, n_mismatch, n_checks, n0;
	// Resolved pins; transmit line pulled high when released
	wire logic   sck_line = sck_oe ? sck_o : sck_ext;
	wire logic   txd_line = txd_oe ? txd_o : 1'b1;

	sss_top i_sss_top
	(
		.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
		.s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
		.s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
		.s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
		.sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe), .txd_o(txd_o), .txd_oe(txd_oe),
		.rxd_i(rxd), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dtx_data), .dma_rx_rd(dma_rx_rd),
		.dma_rx_data(dma_rx_data), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
		.rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq)
	);
	sss_link_partner i_sss_link_partner
	(
		.sck(sck_line), .txd(txd_line), .send_byte(send_byte), .rxd(rxd),
		.got_byte(got_byte), .n_rise(n_rise)
	);

	// Reference clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Bus write; each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		aw_addr <= a;
		w_data <= 32'(d);
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (aw_ready)
				aw_valid <= 1'b0;
			if (w_ready)
				w_valid <= 1'b0;
			if (b_valid)
				break;
		end
		b_ready <= 1'b0;
	endtask

	// Bus read compared at the edge that takes it
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge ref_clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (ar_ready)
				ar_valid <= 1'b0;
			if (r_valid)
				break;
		end
		r_ready <= 1'b0;
		chk({r_resp, r_data}, {r, 24'h00_0000, d});
	endtask

	// Bounded wait for a count of clock pulses at the partner
	task automatic wait_rise(input int k);
		for (int i = 0; i < 4000 && n_rise < k; i++)
			@(posedge ref_clk);
	endtask

	// One-cycle DMA strobe
	task automatic dma_wr(input logic [7:0] d);
		@(posedge ref_clk);
		dtx_data <= d;
		dma_tx_wr <= 1'b1;
		@(posedge ref_clk);
		dma_tx_wr <= 1'b0;
	endtask

	// Verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rstn, aw_valid, w_valid, b_ready, ar_valid, r_ready, dma_tx_wr, dma_rx_rd} = '0;
		{aw_addr, ar_addr, dtx_data, w_data} = '0;
		sck_ext = 1'b1;
		send_byte = 8'h96;
		n_mismatch = 0;
		n_checks = 0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		foreach (rows[i])
			rd_chk(rows[i].a, rows[i].d, rows[i].r);
		// Internal clock, two characters back to back
		wr(8'h00, 8'h80);
		wr(8'h04, 8'h01);
		wr(8'h08, 8'hA4);
		wr(8'h0C, 8'h4B);
		n0 = n_rise;
		wr(8'h10, 8'h00);
		wait_rise(n0 + 4);
		chk({tx_empty_irq, tx_done_irq}, 2'h2);
		wr(8'h0C, 8'h3C);
		wr(8'h10, 8'h00);
		wait_rise(n0 + 8);
		chk(got_byte, 8'h4B);
		wait_rise(n0 + 16);
		chk(got_byte, 8'h3C);
		repeat (60) @(posedge ref_clk);
		chk({n_rise - n0, sck_o, txd_line, tx_done_irq}, {32'd16, 3'h5});
		// Receive, then overrun with the clock still running
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h50);
		for (int i = 0; i < 400 && !rx_full_irq; i++)
			@(posedge ref_clk);
		chk(dma_rx_data, 8'h96);
		send_byte <= 8'h21;
		for (int i = 0; i < 400 && !rx_error_irq; i++)
			@(posedge ref_clk);
		chk({rx_full_irq, rx_error_irq, dma_rx_data}, 10'h196);
		wr(8'h08, 8'h00);
		rd_chk(8'h10, 8'hE4, 2'h0);
		rd_chk(8'h14, 8'h96, 2'h0);
		// No transmit start while the error stands
		wr(8'h08, 8'h20);
		n0 = n_rise;
		dma_wr(8'h5A);
		repeat (100) @(posedge ref_clk);
		chk(n_rise, n0);
		rd_chk(8'h10, 8'h64, 2'h0);
		wr(8'h10, 8'hDF);
		wait_rise(n0 + 8);
		chk(got_byte, 8'h5A);
		@(posedge ref_clk);
		dma_rx_rd <= 1'b1;
		@(posedge ref_clk);
		dma_rx_rd <= 1'b0;
		rd_chk(8'h10, 8'h84, 2'h0);
		// External link clock paces the transmitter
		wr(8'h08, 8'h00);
		wr(8'h08, 8'h22);
		dma_wr(8'hC3);
		repeat (8) @(posedge ref_clk);
		repeat (8)
		begin
			#62.5 sck_ext = 1'b0;
			#62.5 sck_ext = 1'b1;
		end
		repeat (20) @(posedge ref_clk);
		chk({sck_oe, got_byte}, 9'h0C3);
		complete_run();
	end

	// Watchdog
	initial
	begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
